// >>> design/cpg_clock_gen.sv
// Core and peripheral clock generator with its clock control and power control SFRs.
// Assumes clk_i is the crystal input clock; derived clocks leave as enable pulses and the
// debug reset command arrives from the test-clock domain as a level.
`timescale 1ns/10ps
module cpg_clock_gen
   import cpg_pkg::*;
#(
   parameter int WDG_DIV = CPG_WDG_DIV_DEF
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic       sfr_rd_i,
   input  wire logic [7:0] sfr_wdata_i,
   input  wire logic       irq_i,
   input  wire logic       dbg_reset_cmd_i,
   output logic [7:0]      sfr_rdata_o,
   output logic            core_clk_en_o,
   output logic            wdg_clk_en_o,
   output logic            peripheral_clock_en_o,
   output logic            bkpt_compare_enable_o,
   output logic            dbg_func_avail_o,
   output logic            dbg_reset_req_o
);

   // ***********************************************************
   // Elaboration checks
   // ***********************************************************
   initial begin
      if (WDG_DIV < 1 || WDG_DIV > 2048) begin
         $error("cpg_clock_gen: WDG_DIV must lie in 1..2048");
      end
   end

   localparam logic [CPG_DIV_WIDTH-1:0] WDG_TERM = CPG_DIV_WIDTH'(WDG_DIV - 1);

   // ***********************************************************
   // Register state
   // ***********************************************************
   logic [2:0] core_clock_prescale_reg;
   logic [2:0] core_clock_prescale_next;
   logic       auto_restore_full_speed_reg;
   logic       breakpoint_compare_enable_reg;
   logic       power_down_bit_reg;
   logic       power_down_bit_next;
   logic       halt_core_bit_reg;
   logic       halt_core_bit_next;

   logic       wr_clock_control;
   logic       wr_power_control;
   logic       dbg_sync1_reg;
   logic       dbg_sync2_reg;
   logic       dbg_prev_reg;
   logic       dbg_reset_evt;
   logic       core_run;
   logic       core_pulse;
   logic       wdg_pulse;

   // Address decode of the two special function registers
   assign wr_clock_control = sfr_wr_i && (sfr_addr_i == CPG_CLOCK_CONTROL_ADDR);
   assign wr_power_control = sfr_wr_i && (sfr_addr_i == CPG_POWER_CONTROL_ADDR);

   // ***********************************************************
   // Debug reset command crossing
   // ***********************************************************
   // The command is made on the external test clock, so only the link end uses it
   // unsynchronised; here it passes two flops before the edge detector sees it
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         dbg_sync1_reg <= 1'b0;
         dbg_sync2_reg <= 1'b0;
         dbg_prev_reg  <= 1'b0;
      end else begin
         dbg_sync1_reg <= dbg_reset_cmd_i;
         dbg_sync2_reg <= dbg_sync1_reg;
         dbg_prev_reg  <= dbg_sync2_reg;
      end
   end

   assign dbg_reset_evt = dbg_sync2_reg && !dbg_prev_reg;

   // ***********************************************************
   // Clock control register
   // ***********************************************************
   // With auto-restore set, an interrupt wins over a same-cycle write so a wake-up is never lost
   always_comb begin
      core_clock_prescale_next = core_clock_prescale_reg;
      if (wr_clock_control) begin
         core_clock_prescale_next = sfr_wdata_i[CPG_PRESCALE_MSB:CPG_PRESCALE_LSB];
      end
      if (irq_i && auto_restore_full_speed_reg) begin
         core_clock_prescale_next = CPG_PRESCALE_FULL;
      end
   end

   // Stored fields; reset value 10h leaves comparators on
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         core_clock_prescale_reg       <= CPG_CLOCK_CONTROL_RST[CPG_PRESCALE_MSB:CPG_PRESCALE_LSB];
         auto_restore_full_speed_reg   <= CPG_CLOCK_CONTROL_RST[CPG_AUTO_RESTORE_BIT];
         breakpoint_compare_enable_reg <= CPG_CLOCK_CONTROL_RST[CPG_BKPT_ENABLE_BIT];
      end else begin
         core_clock_prescale_reg <= core_clock_prescale_next;
         if (wr_clock_control) begin
            auto_restore_full_speed_reg   <= sfr_wdata_i[CPG_AUTO_RESTORE_BIT];
            breakpoint_compare_enable_reg <= sfr_wdata_i[CPG_BKPT_ENABLE_BIT];
         end
      end
   end

   // ***********************************************************
   // Power control register (low-power bits only)
   // ***********************************************************
   // Interrupt ends halt-core; debug reset ends both modes. Hardware beats software
   always_comb begin
      power_down_bit_next = power_down_bit_reg;
      halt_core_bit_next  = halt_core_bit_reg;
      if (wr_power_control) begin
         power_down_bit_next = sfr_wdata_i[CPG_POWER_DOWN_BIT];
         halt_core_bit_next  = sfr_wdata_i[CPG_HALT_CORE_BIT];
      end
      if (irq_i) begin
         halt_core_bit_next = 1'b0;
      end
      if (dbg_reset_evt) begin
         power_down_bit_next = 1'b0;
         halt_core_bit_next  = 1'b0;
      end
   end

   // Power bits, reset 00h
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         power_down_bit_reg <= CPG_POWER_CONTROL_RST[CPG_POWER_DOWN_BIT];
         halt_core_bit_reg  <= CPG_POWER_CONTROL_RST[CPG_HALT_CORE_BIT];
      end else begin
         power_down_bit_reg <= power_down_bit_next;
         halt_core_bit_reg  <= halt_core_bit_next;
      end
   end

   // ***********************************************************
   // Register read port
   // ***********************************************************
   // Data registered one cycle after the read strobe; reserved and unmapped read zero
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i && sfr_addr_i == CPG_CLOCK_CONTROL_ADDR) begin
         sfr_rdata_o <= {3'h0, breakpoint_compare_enable_reg,
                         auto_restore_full_speed_reg, core_clock_prescale_reg};
      end else if (sfr_rd_i && sfr_addr_i == CPG_POWER_CONTROL_ADDR) begin
         sfr_rdata_o <= {6'h00, power_down_bit_reg, halt_core_bit_reg};
      end else begin
         sfr_rdata_o <= 8'h00;
      end
   end

   // ***********************************************************
   // Clock dividers
   // ***********************************************************
   // Gating holds the divider count where it stands, so a period resumes from that count when the core restarts
   assign core_run = !(power_down_bit_reg || halt_core_bit_reg);

   // Core divider, fed straight from the crystal clock
   cpg_divider #(
      .WIDTH   (CPG_DIV_WIDTH)
   ) u_core_div (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .adv_i   (core_run),
      .term_i  (cpg_div_term(core_clock_prescale_reg)),
      .pulse_o (core_pulse)
   );

   // Watchdog divider advances only on core pulses that survive gating, so a pulse
   // withheld from the core at a low-power entry is never counted by the watchdog
   cpg_divider #(
      .WIDTH   (CPG_DIV_WIDTH)
   ) u_wdg_div (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .adv_i   (core_pulse && core_run),
      .term_i  (WDG_TERM),
      .pulse_o (wdg_pulse)
   );

   // ***********************************************************
   // Outputs
   // ***********************************************************
   // Core enable is re-timed here so that gating acts without a partial pulse
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         core_clk_en_o   <= 1'b0;
         wdg_clk_en_o    <= 1'b0;
         peripheral_clock_en_o <= 1'b0;
      end else begin
         core_clk_en_o   <= core_pulse && core_run;
         wdg_clk_en_o    <= wdg_pulse && core_run;
         peripheral_clock_en_o <= !power_down_bit_next;
      end
   end

   // Debug status: comparator enable, availability, reset request pulse
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bkpt_compare_enable_o <= 1'b1;
         dbg_func_avail_o      <= 1'b1;
         dbg_reset_req_o       <= 1'b0;
      end else begin
         bkpt_compare_enable_o <= breakpoint_compare_enable_reg;
         dbg_func_avail_o      <= !(power_down_bit_next || halt_core_bit_next);
         dbg_reset_req_o       <= dbg_reset_evt;
      end
   end

endmodule : cpg_clock_gen

// >>> include/cpg_pkg.sv
// Constants, register layout and prescale decode for the core/peripheral clock generator.
// Assumes one free-running oscillator clock; derived clocks are one-cycle enable pulses.
//
// Behaviour
// - Every derived clock comes from the crystal input clock alone.
// - Core clock drives core and watchdog; oscillator rate by default, down to 1/2048.
// - Prescale codes select divide by 1, 2, 4, 8, 16, 32, 1024, 2048.
// - A prescale write is used from the very next cycle.
// - Core clock stops while power-down or halt-core bit is set.
// - Watchdog gets a further division of the core clock.
// - Peripheral clock runs at oscillator rate, untouched by the prescaler.
// - Peripheral clock stops only under power-down, never under halt-core.
// - Debug port runs on its own external test clock, reachable in low power.
// - In idle and power-down most debug functions are flagged unavailable.
// - A debug reset command in low power returns the device to normal mode.
// - Clock control bit 4 enables breakpoint comparators; resets to one, writable.
// - Clock control register is 8 bits at F9h, reset 10h, bits 7..5 reserved.
// - With auto-restore set, an interrupt forces the prescale field to 000.
// - Power control register at 87h, reset 00h; bit 1 power-down, bit 0 halt-core.
package cpg_pkg;

   // ***********************************************************
   // Register map
   // ***********************************************************
   localparam logic [7:0] CPG_CLOCK_CONTROL_ADDR = 8'hF9;
   localparam logic [7:0] CPG_CLOCK_CONTROL_RST  = 8'h10;
   localparam logic [7:0] CPG_POWER_CONTROL_ADDR = 8'h87;
   localparam logic [7:0] CPG_POWER_CONTROL_RST  = 8'h00;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int CPG_PRESCALE_LSB      = 0;
   localparam int CPG_PRESCALE_MSB      = 2;
   localparam int CPG_AUTO_RESTORE_BIT  = 3;
   localparam int CPG_BKPT_ENABLE_BIT   = 4;
   localparam int CPG_HALT_CORE_BIT     = 0;
   localparam int CPG_POWER_DOWN_BIT    = 1;
   localparam int CPG_CLOCK_CONTROL_MSB = 4;

   localparam logic [2:0] CPG_PRESCALE_FULL = 3'h0;

   // ***********************************************************
   // Divider sizing and watchdog division
   // ***********************************************************
   localparam int CPG_DIV_WIDTH   = 11;
   localparam int CPG_WDG_DIV_DEF = 16;

   // Terminal count (divisor minus one) for each prescale code
   function automatic logic [CPG_DIV_WIDTH-1:0] cpg_div_term(input logic [2:0] code);
      logic [CPG_DIV_WIDTH-1:0] t;
      t = 11'h000;
      case (code)
         3'h0:    t = 11'h000;
         3'h1:    t = 11'h001;
         3'h2:    t = 11'h003;
         3'h3:    t = 11'h007;
         3'h4:    t = 11'h00F;
         3'h5:    t = 11'h01F;
         3'h6:    t = 11'h3FF;
         3'h7:    t = 11'h7FF;
         default: t = 11'h000;
      endcase
      return t;
   endfunction : cpg_div_term

endpackage : cpg_pkg

// >>> design/cpg_divider.sv
// Enable-pulse divider: one pulse every term_i+1 advancing cycles.
// Assumes term_i comes from logic on the same clock; a changed term restarts the count.
`timescale 1ns/10ps
module cpg_divider
   import cpg_pkg::*;
#(
   parameter int WIDTH = CPG_DIV_WIDTH
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             adv_i,
   input  wire logic [WIDTH-1:0] term_i,
   output logic                  pulse_o
);

   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] term_reg;
   logic [WIDTH-1:0] count_eff;

   initial begin
      if (WIDTH < 1) $error("cpg_divider: WIDTH must be at least 1");
   end

   // A new ratio starts from a clean count, so no pulse comes early or late
   assign count_eff = (term_i != term_reg) ? '0 : count_reg;

   // Counter and pulse; gating only withholds whole pulses
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         count_reg <= '0;
         term_reg  <= '0;
         pulse_o   <= 1'b0;
      end else begin
         term_reg <= term_i;
         pulse_o  <= adv_i && (count_eff == term_i);
         if (adv_i) begin
            count_reg <= (count_eff == term_i) ? '0 : count_eff + 1'b1;
         end else begin
            count_reg <= count_eff;
         end
      end
   end

endmodule : cpg_divider

// >>> dv/cpg_osc_model.sv
// Oscillator model: the crystal or oscillator that feeds the clock input.
// Assumes the bench takes its only clock from this model.
`timescale 1ns/10ps
module cpg_osc_model #(
   parameter real HALF_NS = 4.0
) (
   output logic clk_o
);
   // Free-running source; every derived clock comes from this one
   initial begin
      clk_o = 1'b0;
      forever #(HALF_NS) clk_o = ~clk_o;
   end
endmodule : cpg_osc_model

// >>> dv/cpg_clock_gen_asserts.sv
// Checker: port-level timing relations of the clock generator.
// Assumes it is bound to cpg_clock_gen and sees only its ports.
`timescale 1ns/10ps
module cpg_clock_gen_asserts
   import cpg_pkg::*;
#(
   parameter int WDG_DIV = CPG_WDG_DIV_DEF
) (
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic       sfr_wr_i,
   input wire logic       sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic       irq_i,
   input wire logic       dbg_reset_cmd_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic       core_clk_en_o,
   input wire logic       wdg_clk_en_o,
   input wire logic       peripheral_clock_en_o,
   input wire logic       bkpt_compare_enable_o,
   input wire logic       dbg_func_avail_o,
   input wire logic       dbg_reset_req_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // ********************
   // Register accesses
   // ********************
   sequence cc_wr;
      sfr_wr_i && sfr_addr_i == CPG_CLOCK_CONTROL_ADDR;
   endsequence
   sequence pc_wr;
      sfr_wr_i && sfr_addr_i == CPG_POWER_CONTROL_ADDR;
   endsequence
   rd_idle_zero_a: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
      else $error("read data not zero without a read");
   unmapped_rd_a: assert property (sfr_rd_i
      && sfr_addr_i != CPG_CLOCK_CONTROL_ADDR
      && sfr_addr_i != CPG_POWER_CONTROL_ADDR |=> sfr_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   cc_reserved_a: assert property (sfr_rd_i && sfr_addr_i == CPG_CLOCK_CONTROL_ADDR
      |=> sfr_rdata_o[7:5] == 3'h0)
      else $error("clock control reserved bits set");
   pc_reserved_a: assert property (sfr_rd_i && sfr_addr_i == CPG_POWER_CONTROL_ADDR
      |=> sfr_rdata_o[7:2] == 6'h00)
      else $error("power control unused bits set");
   // A sequence cannot be negated, so the idle cycle is spelled out as a plain condition
   bkpt_follow_a: assert property (cc_wr
      ##1 !(sfr_wr_i && sfr_addr_i == CPG_CLOCK_CONTROL_ADDR)
      |=> bkpt_compare_enable_o == $past(sfr_wdata_i[CPG_BKPT_ENABLE_BIT], 2))
      else $error("breakpoint enable does not follow bit 4");
   // Power-down stops the peripheral clock; halt-core alone never does
   pwrdn_stops_periph_a: assert property (pc_wr ##0 sfr_wdata_i[1]
      |=> dbg_reset_req_o || !peripheral_clock_en_o)
      else $error("peripheral clock runs in power-down");
   idle_keeps_periph_a: assert property (pc_wr ##0 sfr_wdata_i[1:0] == 2'h1
      |=> peripheral_clock_en_o)
      else $error("halt-core stopped peripheral clock");
   halt_avail_a: assert property (pc_wr
      ##0 (sfr_wdata_i[1] || (sfr_wdata_i[0] && !irq_i))
      |=> dbg_reset_req_o || !dbg_func_avail_o)
      else $error("debug still available in low power");
   avail_gates_core_a: assert property (!dbg_func_avail_o [*3]
      |-> !core_clk_en_o && !wdg_clk_en_o)
      else $error("core or watchdog pulse in low power");
   avail_periph_a: assert property ($past(rst_n_i) && dbg_func_avail_o
      |-> peripheral_clock_en_o)
      else $error("peripheral clock stopped in normal mode");
   dbg_pulse_a: assert property (dbg_reset_req_o
      |-> dbg_func_avail_o && peripheral_clock_en_o ##1 !dbg_reset_req_o)
      else $error("debug reset did not restore normal mode");
   wdg_after_core_a: assert property (wdg_clk_en_o |-> $past(core_clk_en_o))
      else $error("watchdog pulse without core pulse");
endmodule : cpg_clock_gen_asserts

// >>> dv/cpg_clock_gen_tb.sv
// Testbench: prescale table, register map, power gating and debug reset.
// Assumes the oscillator model supplies the clock; inputs move on the falling edge.
`timescale 1ns/10ps
module cpg_clock_gen_tb;
   import cpg_pkg::*;
   localparam int WDG = 2; // Short watchdog division keeps the run brief
   logic       clk;
   logic       rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0, rd = 1'b0, irq = 1'b0, dbg = 1'b0;
   logic [7:0] rdata, d;
   logic       core, wdg, periph, bkpt, avail, req;
   int         error_cnt = 0, n_tests = 0, n, p;
   logic [7:0] row_d [8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
   int         row_p [8] = '{1, 2, 4, 8, 16, 32, 1024, 2048};

   cpg_osc_model u_osc (.clk_o(clk));
   cpg_clock_gen #(.WDG_DIV(WDG)) uut (.clk_i(clk), .rst_n_i(rst_n), .sfr_addr_i(addr),
      .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .irq_i(irq), .dbg_reset_cmd_i(dbg),
      .sfr_rdata_o(rdata), .core_clk_en_o(core), .wdg_clk_en_o(wdg),
      .peripheral_clock_en_o(periph), .bkpt_compare_enable_o(bkpt), .dbg_func_avail_o(avail),
      .dbg_reset_req_o(req));

   // ********************
   // Bus, sampling and compare tasks
   // ********************
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      addr = a;
      wdata = v;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : sfr_wr
   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      v = rdata;
   endtask : sfr_rd
   task automatic pulse_irq;
      @(negedge clk);
      irq = 1'b1;
      @(negedge clk);
      irq = 1'b0;
   endtask : pulse_irq
   function automatic logic pick(input int s);
      return (s == 0) ? core : (s == 1) ? wdg : (s == 2) ? periph : req;
   endfunction : pick
   // Cycles to first pulse, then the pulse period; bounded so a dead clock cannot hang
   task automatic meas(input int s, output int n, output int p);
      n = 0;
      p = 0;
      do begin
         @(negedge clk);
         n++;
      end while (pick(s) !== 1'b1 && n < 5000);
      do begin
         @(negedge clk);
         p++;
      end while (pick(s) !== 1'b1 && p < 5000);
   endtask : meas
   task automatic cnt(input int s, input int c, output int k);
      k = 0;
      repeat (c) begin
         @(negedge clk);
         if (pick(s) === 1'b1) k++;
      end
   endtask : cnt
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // ********************
   // Main sequence and watchdog
   // ********************
   initial begin
      #(50000 * 8);
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      sfr_rd(CPG_CLOCK_CONTROL_ADDR, d);
      chk("cc_reset", 8'h10, d);
      sfr_rd(CPG_POWER_CONTROL_ADDR, d);
      chk("pc_reset", 8'h00, d);
      sfr_rd(8'hA5, d);
      chk("unmapped", 8'h00, d);
      chk("bkpt_reset", 1, bkpt);
      chk("core_full", 1, core);
      // Each row selects one prescale code and measures the period right away
      for (int i = 0; i < 8; i++) begin
         sfr_wr(CPG_CLOCK_CONTROL_ADDR, row_d[i]);
         meas(0, n, p);
         chk("first_pulse", 1, n <= row_p[i] + 2);
         chk("core_period", row_p[i], p);
         sfr_rd(CPG_CLOCK_CONTROL_ADDR, d);
         chk("cc_readback", row_d[i], d);
      end
      sfr_wr(CPG_CLOCK_CONTROL_ADDR, 8'hE1);
      sfr_rd(CPG_CLOCK_CONTROL_ADDR, d);
      chk("cc_reserved", 8'h01, d);
      chk("bkpt_clear", 0, bkpt);
      meas(1, n, p);
      chk("wdg_period", 2 * WDG, p);
      meas(2, n, p);
      chk("periph_period", 1, p);
      sfr_wr(CPG_CLOCK_CONTROL_ADDR, 8'h0D);
      pulse_irq();
      sfr_rd(CPG_CLOCK_CONTROL_ADDR, d);
      chk("auto_restore", 8'h08, d);
      sfr_wr(CPG_CLOCK_CONTROL_ADDR, 8'h05);
      pulse_irq();
      sfr_rd(CPG_CLOCK_CONTROL_ADDR, d);
      chk("no_restore", 8'h05, d);
      sfr_wr(CPG_CLOCK_CONTROL_ADDR, 8'h00);
      sfr_wr(CPG_POWER_CONTROL_ADDR, 8'h01);
      cnt(0, 40, n);
      chk("idle_core", 0, n);
      chk("idle_avail", 0, avail);
      cnt(2, 40, n);
      chk("idle_periph", 40, n);
      pulse_irq();
      sfr_rd(CPG_POWER_CONTROL_ADDR, d);
      chk("idle_exit", 8'h00, d);
      sfr_wr(CPG_POWER_CONTROL_ADDR, 8'h02);
      cnt(2, 40, n);
      chk("pwrdn_periph", 0, n);
      cnt(0, 40, n);
      chk("pwrdn_core", 0, n);
      dbg = 1'b1;
      cnt(3, 12, n);
      chk("dbg_pulse", 1, n);
      dbg = 1'b0;
      sfr_rd(CPG_POWER_CONTROL_ADDR, d);
      chk("dbg_exit", 8'h00, d);
      chk("dbg_avail", 1, avail);
      cnt(0, 10, n);
      chk("dbg_core", 10, n);
      // Mid-run reset must bring every clock control field back to its reset value
      sfr_wr(CPG_CLOCK_CONTROL_ADDR, 8'h0F);
      rst_n = 1'b0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      sfr_rd(CPG_CLOCK_CONTROL_ADDR, d);
      chk("cc_rerst", 8'h10, d);
      chk("bkpt_rerst", 1, bkpt);
      finish_test();
   end
endmodule : cpg_clock_gen_tb

bind cpg_clock_gen cpg_clock_gen_asserts #(.WDG_DIV(WDG_DIV)) u_chk (.clk_i, .rst_n_i,
   .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .irq_i, .dbg_reset_cmd_i, .sfr_rdata_o,
   .core_clk_en_o, .wdg_clk_en_o, .peripheral_clock_en_o, .bkpt_compare_enable_o,
   .dbg_func_avail_o, .dbg_reset_req_o);
